// *** pcp_pad_bank.sv ***
// Purpose: apb-mapped pad control bank for pins 39 to 44
// Assumes: apb slave, zero wait states, clk_sys_i at 25 MHz
// Notes: vector index 0 is pin 39 ... index 5 is pin 44
//
// Overview of operation
// RQ1 - drive strength code in bits 14:12
// RQ2 - bit 9 enables weak pull-down
// RQ3 - bit 8 enables weak pull-up
// RQ4 - bit 7 enables pad input buffer
// RQ5 - bit 6 enables pad output driver
// RQ6 - bit 4 selects analog, resets analog
// RQ7 - reserved bits read zero, ignore writes
// RQ8 - registers decoded 0xa8 to 0xbc pin order
// RQ9 - analog routing joins pad to partner signal
// RQ10 - output level from second data register
// RQ11 - pin 40 register sits at 0xac
module pcp_pad_bank
    import pcp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PCP_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // output data bits for pins 39 to 44 (from second data register)
    input wire logic [PCP_NUM_PINS-1:0] output_level_bits_i,
    // pad controls, index 0 is pin 39
    output logic [3*PCP_NUM_PINS-1:0] drive_strength_sel_o,
    output logic [PCP_NUM_PINS-1:0] weak_pulldown_en_o,
    output logic [PCP_NUM_PINS-1:0] weak_pullup_en_o,
    output logic [PCP_NUM_PINS-1:0] pad_input_en_o,
    output logic [PCP_NUM_PINS-1:0] pad_output_en_o,
    output logic [PCP_NUM_PINS-1:0] pad_out_o,
    // analog routing switches
    output logic regulator_sense_sel_o,
    output logic aux_in0_left_sel_o,
    output logic aux_in0_right_sel_o,
    output logic audio_out_left_sel_o,
    output logic audio_out_right_sel_o,
    output logic aux_in1_left_sel_o
);
    logic [PCP_NUM_PINS-1:0] hit;
    logic [PCP_NUM_PINS-1:0] wr;
    logic [PCP_NUM_PINS-1:0] analog_sel;
    logic [31:0] rdata [PCP_NUM_PINS];
    logic [31:0] rd_mux;
    logic any_hit;
    logic [11:0] ofs_tbl [PCP_NUM_PINS];
    logic access_ok;

    // bus phase seen at the last edge; an enable with no setup before it never writes
    typedef enum logic [1:0]
    {
        phase_idle,
        phase_setup,
        phase_access
    } pcp_phase_t;
    pcp_phase_t phase_reg;
    pcp_phase_t phase_next;

    assign ofs_tbl[0] = PCP_OFS_PIN39;
    assign ofs_tbl[1] = PCP_OFS_PIN40; // see RQ11
    assign ofs_tbl[2] = PCP_OFS_PIN41;
    assign ofs_tbl[3] = PCP_OFS_PIN42;
    assign ofs_tbl[4] = PCP_OFS_PIN43;
    assign ofs_tbl[5] = PCP_OFS_PIN44;

    genvar g;
    generate
        for (g = 0; g < PCP_NUM_PINS; g++)
        begin : g_pin
            assign hit[g] = (paddr_i == ofs_tbl[g]); // see RQ8
            // write lands at the apb access edge; partial strobes still write
            // whole field set, since fields sit in bytes 0 and 1 only
            assign wr[g] = psel_i && penable_i && pwrite_i && hit[g]
                && (pstrb_i != 4'h0) && access_ok;
            pcp_pin_ctl u_pin (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .wr_i(wr[g]),
                .wdata_i(pwdata_i & PCP_WR_MASK), // see RQ7
                .rdata_o(rdata[g]),
                .out_level_i(output_level_bits_i[g]), // see RQ10
                .drive_strength_sel_o(drive_strength_sel_o[3*g+2:3*g]),
                .weak_pulldown_en_o(weak_pulldown_en_o[g]),
                .weak_pullup_en_o(weak_pullup_en_o[g]),
                .pad_input_en_o(pad_input_en_o[g]),
                .pad_output_en_o(pad_output_en_o[g]),
                .analog_sel_o(analog_sel[g]),
                .pad_out_o(pad_out_o[g])
            );
        end
    endgenerate

    always_comb
    begin
        phase_next = phase_idle;
        unique case (phase_reg)
            phase_idle, phase_access:
            begin
                if (psel_i && !penable_i)
                begin
                    phase_next = phase_setup;
                end
            end
            phase_setup:
            begin
                if (psel_i && penable_i)
                begin
                    phase_next = phase_access;
                end
                else if (psel_i)
                begin
                    phase_next = phase_setup;
                end
            end
            default:
            begin
                phase_next = phase_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            phase_reg <= phase_idle;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    // only the cycle right after a setup is a legal access cycle
    assign access_ok = (phase_reg == phase_setup); // see RQ8

    assign any_hit = |hit;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < PCP_NUM_PINS; i++)
        begin
            if (hit[i])
            begin
                rd_mux = rdata[i];
            end
        end
    end

    // answer registered in setup, valid in access cycle: zero wait states
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            pready_o <= 1'h0;
            pslverr_o <= 1'h0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !any_hit;
            prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // analog switches, one per pad in pin order
    assign regulator_sense_sel_o = analog_sel[0]; // see RQ9
    assign aux_in0_left_sel_o = analog_sel[1]; // see RQ9
    assign aux_in0_right_sel_o = analog_sel[2]; // see RQ9
    assign audio_out_left_sel_o = analog_sel[3]; // see RQ9
    assign audio_out_right_sel_o = analog_sel[4]; // see RQ9
    assign aux_in1_left_sel_o = analog_sel[5]; // see RQ9
endmodule

// *** pcp_pkg.sv ***
// Purpose: shared constants for the pad control bank, pins 39 to 44
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes: offsets are byte addresses within the peripheral map
package pcp_pkg;
    localparam int PCP_NUM_PINS = 6;
    localparam int PCP_ADDR_W = 12;
    localparam logic [11:0] PCP_OFS_PIN39 = 12'h0a8;
    localparam logic [11:0] PCP_OFS_PIN40 = 12'h0ac;
    localparam logic [11:0] PCP_OFS_PIN41 = 12'h0b0;
    localparam logic [11:0] PCP_OFS_PIN42 = 12'h0b4;
    localparam logic [11:0] PCP_OFS_PIN43 = 12'h0b8;
    localparam logic [11:0] PCP_OFS_PIN44 = 12'h0bc;
    // field positions
    localparam int PCP_DRV_LSB = 12;
    localparam int PCP_DRV_MSB = 14;
    localparam int PCP_PD_BIT = 9;
    localparam int PCP_PU_BIT = 8;
    localparam int PCP_IE_BIT = 7;
    localparam int PCP_OE_BIT = 6;
    localparam int PCP_AN_BIT = 4;
    // writable bits only; everything else reads zero
    localparam logic [31:0] PCP_WR_MASK = 32'h0000_73d0;
    // reset values
    localparam logic [2:0] PCP_DRV_RST = 3'h1;
    localparam logic PCP_PD_RST = 1'h0;
    localparam logic PCP_PU_RST = 1'h0;
    localparam logic PCP_IE_RST = 1'h0;
    localparam logic PCP_OE_RST = 1'h0;
    localparam logic PCP_AN_RST = 1'h1;
    localparam logic [31:0] PCP_CTL_RST = 32'h0000_1010;
    // apb answers in the access cycle, no wait states
    localparam int PCP_APB_WAIT = 0;
endpackage

// *** pcp_pin_ctl.sv ***
// Purpose: one pin's pad control register and its pad steering
// Assumes: write strobe is a single cycle, data already masked by caller
// Notes: pad outputs registered; rdata_o is combinational from the register
module pcp_pin_ctl
    import pcp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register access
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    // output level from the data register
    input wire logic out_level_i,
    // pad controls
    output logic [2:0] drive_strength_sel_o,
    output logic weak_pulldown_en_o,
    output logic weak_pullup_en_o,
    output logic pad_input_en_o,
    output logic pad_output_en_o,
    output logic analog_sel_o,
    output logic pad_out_o
);
    logic [2:0] drv_reg;
    logic pd_reg;
    logic pu_reg;
    logic ie_reg;
    logic oe_reg;
    logic an_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            drv_reg <= PCP_DRV_RST;
            pd_reg <= PCP_PD_RST;
            pu_reg <= PCP_PU_RST;
            ie_reg <= PCP_IE_RST;
            oe_reg <= PCP_OE_RST;
            an_reg <= PCP_AN_RST;
        end
        else if (wr_i)
        begin
            drv_reg <= wdata_i[PCP_DRV_MSB:PCP_DRV_LSB]; // see RQ1
            pd_reg <= wdata_i[PCP_PD_BIT]; // see RQ2
            pu_reg <= wdata_i[PCP_PU_BIT]; // see RQ3
            ie_reg <= wdata_i[PCP_IE_BIT]; // see RQ4
            oe_reg <= wdata_i[PCP_OE_BIT]; // see RQ5
            an_reg <= wdata_i[PCP_AN_BIT]; // see RQ6
        end
    end

    // readback built from fields so reserved bits are always zero
    always_comb
    begin
        rdata_o = 32'h0000_0000; // see RQ7
        rdata_o[PCP_DRV_MSB:PCP_DRV_LSB] = drv_reg;
        rdata_o[PCP_PD_BIT] = pd_reg;
        rdata_o[PCP_PU_BIT] = pu_reg;
        rdata_o[PCP_IE_BIT] = ie_reg;
        rdata_o[PCP_OE_BIT] = oe_reg;
        rdata_o[PCP_AN_BIT] = an_reg;
    end

    // pad controls follow the register one cycle later so outputs are flops
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            drive_strength_sel_o <= PCP_DRV_RST;
            weak_pulldown_en_o <= PCP_PD_RST;
            weak_pullup_en_o <= PCP_PU_RST;
            pad_input_en_o <= PCP_IE_RST;
            pad_output_en_o <= PCP_OE_RST;
            analog_sel_o <= PCP_AN_RST;
            pad_out_o <= 1'h0;
        end
        else
        begin
            drive_strength_sel_o <= drv_reg; // see RQ1
            weak_pulldown_en_o <= pd_reg; // see RQ2
            weak_pullup_en_o <= pu_reg; // see RQ3
            pad_input_en_o <= ie_reg && !an_reg; // see RQ4
            // digital drive only when routed digital, avoids fighting the analog net
            pad_output_en_o <= oe_reg && !an_reg; // see RQ5
            analog_sel_o <= an_reg; // see RQ6
            pad_out_o <= out_level_i && oe_reg && !an_reg; // see RQ10
        end
    end
endmodule

// *** pcp_pad_bank_chk.sv ***
// Purpose: port checks for the pad bank
// Assumes: zero wait apb
// Notes: bound below
module pcp_pad_bank_chk
    import pcp_pkg::*;
(
    input logic clk_sys_i, reset_i, psel_i, penable_i, pready_o, pslverr_o,
    input logic [11:0] paddr_i,
    input logic [31:0] prdata_o,
    input logic [17:0] drive_strength_sel_o,
    input logic [5:0] output_level_bits_i, pad_input_en_o, pad_output_en_o, pad_out_o,
    input logic regulator_sense_sel_o, aux_in0_left_sel_o, aux_in0_right_sel_o,
    input logic audio_out_left_sel_o, audio_out_right_sel_o, aux_in1_left_sel_o
);
    wire [5:0] an = {aux_in1_left_sel_o, audio_out_right_sel_o, audio_out_left_sel_o,
        aux_in0_right_sel_o, aux_in0_left_sel_o, regulator_sense_sel_o};
    wire su = psel_i && !penable_i;
    wire hit = paddr_i >= 12'h0a8 && paddr_i <= 12'h0bc && paddr_i[1:0] == 2'h0;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    ready_ack_a: assert property (su |=> pready_o) else $error("no ready");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
    unmapped_err_a: assert property (su && !hit |=> pslverr_o && prdata_o == 32'h0)
        else $error("no error");
    mapped_ok_a: assert property (su && hit |=> !pslverr_o) else $error("bad error");
    rsvd_zero_a: assert property ((prdata_o & ~PCP_WR_MASK) == 32'h0)
        else $error("reserved set");
    an_gate_a: assert property (((pad_input_en_o | pad_output_en_o) & an) == 6'h0)
        else $error("analog leak");
    pad_level_a: assert property
        (pad_out_o == ($past(output_level_bits_i) & pad_output_en_o)) else $error("pad level");
    reset_val_a: assert property
        ($past(reset_i) |-> drive_strength_sel_o == 18'h9249 && an == 6'h3f) else $error("reset");
    cover property (su && hit);
    cover property (su && !hit);
    cover property (|pad_out_o);
endmodule

bind pcp_pad_bank pcp_pad_bank_chk pcp_pad_bank_chk_i (.clk_sys_i, .reset_i, .psel_i,
    .penable_i, .pready_o, .pslverr_o, .paddr_i, .prdata_o, .drive_strength_sel_o,
    .output_level_bits_i, .pad_input_en_o, .pad_output_en_o, .pad_out_o, .regulator_sense_sel_o,
    .aux_in0_left_sel_o, .aux_in0_right_sel_o, .audio_out_left_sel_o, .audio_out_right_sel_o,
    .aux_in1_left_sel_o);

// *** pcp_pad_bank_bench.sv ***
// Purpose: bench for the pad bank
// Assumes: zero wait apb
// Notes: pin i sits at 0xa8 plus 4i
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pcp_pad_bank_bench
    import pcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'h0, reset_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic err;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, rd;
    logic [5:0] lvl = 6'h15;
    logic [3:0] strb = 4'hf;
    wire [31:0] q;
    wire rdy, se;
    wire [17:0] drv;
    wire [5:0] pd, pu, ie, oe, po, an;
    int fails = 0, samples_checked = 0;
    pcp_pad_bank pcp_pad_bank_i (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .pstrb_i(strb), .prdata_o(q), .pready_o(rdy), .pslverr_o(se),
        .output_level_bits_i(lvl), .drive_strength_sel_o(drv), .weak_pulldown_en_o(pd),
        .weak_pullup_en_o(pu), .pad_input_en_o(ie), .pad_output_en_o(oe), .pad_out_o(po),
        .regulator_sense_sel_o(an[0]), .aux_in0_left_sel_o(an[1]), .aux_in0_right_sel_o(an[2]),
        .audio_out_left_sel_o(an[3]), .audio_out_right_sel_o(an[4]), .aux_in1_left_sel_o(an[5]));
    always #20 clk_sys_i = ~clk_sys_i;
    // request stands until pready is sampled high at a rising edge, answer taken there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'h1;
        do
            @(posedge clk_sys_i);
        while (rdy !== 1'h1);
        rd = q;
        err = se;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    task automatic pin(input int i, input logic [31:0] v);
        logic dg;
        dg = ~v[4];
        apb(1'h1, 12'h0a8 + 12'(4 * i), v);
        apb(1'h0, 12'h0a8 + 12'(4 * i), '0);
        `CHK("word", {1'h0, v & PCP_WR_MASK}, {err, rd})
        `CHK("drive", v[14:12], drv[3*i +: 3])
        `CHK("pulls", v[9:8], {pd[i], pu[i]})
        `CHK("enables", v[7:6] & {dg, dg}, {ie[i], oe[i]})
        `CHK("route", {v[4], lvl[i] & v[6] & dg}, {an[i], po[i]})
    endtask
    task automatic t_reset();
        for (int i = 0; i < 6; i++)
        begin
            apb(1'h0, 12'h0a8 + 12'(4 * i), '0);
            `CHK("reset word", 32'h1010, rd)
        end
        `CHK("reset pads", {18'h9249, 6'h3f, 30'h0}, {drv, an, pd, pu, ie, oe, po})
        $display("test reset done");
    endtask
    task automatic t_fields();
        lvl <= 6'h2a;
        for (int c = 0; c < 8; c++)
            pin(0, {17'h0, 3'(c), 12'h3c0});
        for (int i = 0; i < 6; i++)
        begin
            pin(i, {17'h1ffff, 3'(i + 3), 2'h3, i[0], ~i[0], 8'hef});
            pin(i, 32'h13d0);
        end
        $display("test fields done");
    endtask
    task automatic t_unmapped();
        logic [11:0] bad [3] = '{12'h0a4, 12'h0c0, 12'h0fc};
        foreach (bad[k])
        begin
            apb(1'h1, bad[k], '1);
            `CHK("write error", 1'h1, err)
            apb(1'h0, bad[k], '0);
            `CHK("read error", {1'h1, 32'h0}, {err, rd})
        end
        apb(1'h0, 12'h0bc, '0);
        `CHK("kept", 32'h13d0, rd)
        strb <= 4'h0;
        apb(1'h1, 12'h0a8, '1);
        strb <= 4'hf;
        apb(1'h0, 12'h0a8, '0);
        `CHK("no strobe", 32'h13d0, rd)
        $display("test unmapped done");
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2000) @(posedge clk_sys_i);
        fails++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'h0;
        t_reset();
        t_fields();
        t_unmapped();
        reset_i <= 1'h1;
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'h0;
        t_reset();
        summarize();
    end
endmodule
